/* include/csc_pkg.sv */
package csc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_HF_STATUS = 12'h40C;
  localparam logic [11:0] OFF_LF_TRIG = 12'h414;
  localparam logic [11:0] OFF_LF_STATUS = 12'h418;
  localparam logic [11:0] OFF_LF_SNAP = 12'h41C;
  localparam logic [11:0] OFF_LF_SEL = 12'h518;
  localparam logic [11:0] OFF_CAL_IV = 12'h538;
  localparam logic [11:0] OFF_START_TASK = 12'h008;
  localparam int HF_SRC_BIT = 0;
  localparam int HF_STATE_BIT = 16;
  localparam int LF_SRC_LSB = 0;
  localparam int LF_BYPASS_BIT = 16;
  localparam int LF_EXT_BIT = 17;
  localparam int LF_STATE_BIT = 16;
  localparam int CAL_W = 7;
  localparam logic [1:0] SRC_RC = 2'h0;
  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_SYNTH = 2'h2;
  localparam logic [3:0] LF_SEL_RESET = 4'h0;
  localparam logic [6:0] CAL_IV_RESET = 7'h01;
  localparam int CAL_STEP_MS = 250;
  typedef struct packed {
    logic ext;
    logic bypass;
    logic [1:0] src;
  } csc_lfsel_t;
endpackage

/* hdl/csc_retained_reg.sv */
`timescale 1ns/1ps
// holds its value across loss of the unit reset; only a power-on reset loads INIT
module csc_retained_reg #(
  parameter int W = 7,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic por_n,
  input wire logic we,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] value_q
);
  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      value_q <= INIT;
    end else if (we) begin
      value_q <= wdata;
    end
  end
endmodule

/* hdl/csc_sync2.sv */
`timescale 1ns/1ps
// two-flop synchroniser per bit
module csc_sync2 #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      q <= '0;
    end else begin
      s1_q <= d;
      q <= s1_q;
    end
  end
endmodule

/* hdl/csc_top.sv */
`timescale 1ns/1ps
// Operation
// - fast clock status shows running bit and source crystal-or-internal, read only
// - read-only flag shows slow start task fired since reset
// - start task copies current slow source selection into snapshot register
// - slow source field: 0 rc, 1 crystal, 2 synthesized from fast clock
// - bypass bit 1 bypasses slow crystal oscillator for rail-to-rail clock
// - external bit 1 uses external signal instead of crystal
// - source selection register resets to all zero
// - calibration interval retained, covers 0.25 s to 31.75 s
// - calibration interval lives in a retained register
module csc_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [csc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hf_running,
  input wire logic hf_from_crystal,
  input wire logic lf_running,
  input wire logic [1:0] lf_active_src,
  output logic [1:0] lf_src_sel,
  output logic lf_bypass,
  output logic lf_external,
  output logic lf_start_pulse,
  output logic [csc_pkg::CAL_W-1:0] cal_interval
);
  import csc_pkg::*;

  logic [4:0] stat_s;
  logic [1:0] lf_act_s;
  csc_lfsel_t sel_q;
  csc_lfsel_t snap_q;
  logic trig_q;
  logic [CAL_W-1:0] cal_q;
  logic access;
  logic wr;
  logic task_wr;
  logic cal_we;
  logic [31:0] rdata;
  logic hit;

  csc_sync2 #(.W(5)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({lf_active_src, lf_running, hf_from_crystal, hf_running}),
    .q(stat_s)
  );
  assign lf_act_s = stat_s[4:3];

  assign access = psel && penable;
  assign wr = access && pwrite;
  assign task_wr = wr && (paddr == OFF_START_TASK) && pwdata[0];
  assign cal_we = wr && (paddr == OFF_CAL_IV);

  csc_retained_reg #(.W(CAL_W), .INIT(CAL_IV_RESET)) u_cal (
    .clock(clock),
    .por_n(por_n),
    .we(cal_we),
    .wdata(pwdata[CAL_W-1:0]),
    .value_q(cal_q)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= LF_SEL_RESET;
    end else if (wr && paddr == OFF_LF_SEL) begin
      sel_q.src <= pwdata[LF_SRC_LSB +: 2];
      sel_q.bypass <= pwdata[LF_BYPASS_BIT];
      sel_q.ext <= pwdata[LF_EXT_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      snap_q <= LF_SEL_RESET;
      trig_q <= 1'b0;
    end else if (task_wr) begin
      snap_q <= sel_q;
      trig_q <= 1'b1;
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == OFF_HF_STATUS) begin
      rdata[HF_SRC_BIT] = stat_s[1];
      rdata[HF_STATE_BIT] = stat_s[0];
    end else if (paddr == OFF_LF_TRIG) begin
      rdata[0] = trig_q;
    end else if (paddr == OFF_LF_STATUS) begin
      rdata[LF_SRC_LSB +: 2] = lf_act_s;
      rdata[LF_STATE_BIT] = stat_s[2];
    end else if (paddr == OFF_LF_SNAP) begin
      rdata[LF_SRC_LSB +: 2] = snap_q.src;
      rdata[LF_BYPASS_BIT] = snap_q.bypass;
      rdata[LF_EXT_BIT] = snap_q.ext;
    end else if (paddr == OFF_LF_SEL) begin
      rdata[LF_SRC_LSB +: 2] = sel_q.src;
      rdata[LF_BYPASS_BIT] = sel_q.bypass;
      rdata[LF_EXT_BIT] = sel_q.ext;
    end else if (paddr == OFF_CAL_IV) begin
      rdata[CAL_W-1:0] = cal_q;
    end else if (paddr == OFF_START_TASK) begin
      rdata = 32'h0000_0000;
    end else begin
      hit = 1'b0;
    end
  end

  // zero-wait slave: pready registered high during each access cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= rdata;
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lf_src_sel <= SRC_RC;
      lf_bypass <= 1'b0;
      lf_external <= 1'b0;
      lf_start_pulse <= 1'b0;
      cal_interval <= CAL_IV_RESET;
    end else begin
      lf_src_sel <= sel_q.src;
      lf_bypass <= sel_q.bypass;
      lf_external <= sel_q.ext;
      lf_start_pulse <= task_wr;
      cal_interval <= cal_q;
    end
  end
endmodule

/* verif/csc_monitor.sv */
`timescale 1ns/1ps
module csc_monitor (
  input logic clock,
  input logic rst_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [csc_pkg::ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic pready,
  input logic [1:0] lf_src_sel,
  input logic lf_bypass,
  input logic lf_external,
  input logic lf_start_pulse
);
  import csc_pkg::*;
  logic wa, ws, wt;
  assign wa = psel && penable && pwrite;
  assign ws = wa && paddr == OFF_LF_SEL;
  assign wt = wa && paddr == OFF_START_TASK && pwdata[0];
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_src_write: assert property (
    ws |-> ##2 lf_src_sel == $past(pwdata[1:0], 2)) else $error("src");
  a_byp_write: assert property (
    ws |-> ##2 lf_bypass == $past(pwdata[16], 2)) else $error("bypass");
  a_ext_write: assert property (
    ws |-> ##2 lf_external == $past(pwdata[17], 2)) else $error("ext");
  a_sel_hold: assert property (
    !ws |=> ##1 $stable({lf_src_sel, lf_bypass, lf_external}))
    else $error("sel");
  a_sel_reset: assert property (
    $rose(rst_n) |-> lf_src_sel == SRC_RC && !lf_bypass && !lf_external)
    else $error("sel reset");
  a_start_go: assert property (wt |=> lf_start_pulse)
    else $error("start");
  a_start_why: assert property (lf_start_pulse |-> $past(wt))
    else $error("pulse");
  a_ready_due: assert property (psel && !penable |=> pready)
    else $error("ready");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready2");
  cover property (wt);
  cover property (ws && pwdata[17]);
  cover property (pready);
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import csc_pkg::*;
  logic clock = 0, rst_n = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic hf_running = 0, hf_from_crystal = 0, lf_running = 0, e;
  logic [1:0] lf_active_src = 0, lf_src_sel;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, v, seed = 32'hFEEEC258;
  logic pready, pslverr, lf_bypass, lf_external, lf_start_pulse;
  logic [6:0] cal_interval;
  int errors = 0, num_checks = 0;
  always #10 clock = ~clock;
  csc_top DUT (
    .clock(clock), .rst_n(rst_n), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hf_running(hf_running), .hf_from_crystal(hf_from_crystal),
    .lf_running(lf_running), .lf_active_src(lf_active_src),
    .lf_src_sel(lf_src_sel), .lf_bypass(lf_bypass),
    .lf_external(lf_external), .lf_start_pulse(lf_start_pulse),
    .cal_interval(cal_interval)
  );
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] sm(input logic [31:0] d);
    return d & 32'h00030003;
  endfunction
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock) penable <= 1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 9);
    if (pready !== 1'b1) begin
      errors++;
      $display("MISMATCH %0t no pready", $time);
      test_done;
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clock);
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1;
    por_n <= 1;
    @(posedge clock);
    apb(0, OFF_LF_SEL, 0);
    chk(r, 0);
    apb(0, OFF_CAL_IV, 0);
    chk(r, 32'(CAL_IV_RESET));
    apb(0, OFF_LF_TRIG, 0);
    chk(r, 0);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      v = xs();
      v[1:0] = 2'(i % 3);
      if (v[17]) v[1:0] = SRC_XTAL;
      {hf_running, hf_from_crystal, lf_running, lf_active_src} <= v[8:4];
      apb(1, OFF_LF_SEL, v);
      apb(0, OFF_LF_SEL, 0);
      chk(r, sm(v));
      chk(32'(e), 0);
      chk(32'(lf_src_sel), 32'(v[1:0]));
      chk(32'({lf_external, lf_bypass}), 32'(v[17:16]));
      apb(0, OFF_HF_STATUS, 0);
      chk(r, {15'h0, hf_running, 15'h0, hf_from_crystal});
      apb(0, OFF_LF_STATUS, 0);
      chk(r, {15'h0, lf_running, 14'h0, lf_active_src});
    end
    $display("select test done");
    apb(1, OFF_START_TASK, 1);
    apb(1, OFF_LF_SEL, 0);
    apb(0, OFF_LF_SNAP, 0);
    chk(r, sm(v));
    apb(0, OFF_LF_TRIG, 0);
    chk(r, 1);
    $display("start test done");
    apb(1, OFF_CAL_IV, 127);
    rst_n <= 0;
    repeat (2) @(posedge clock);
    rst_n <= 1;
    @(posedge clock);
    apb(0, OFF_CAL_IV, 0);
    chk(r, 127);
    chk(32'(cal_interval), 127);
    apb(0, OFF_LF_TRIG, 0);
    chk(r, 0);
    apb(0, OFF_LF_SEL, 0);
    chk(r, 0);
    apb(0, 12'h100, 0);
    chk(r, 0);
    chk(32'(e), 1);
    $display("retain test done");
    test_done;
  end
endmodule
bind csc_top csc_monitor MON (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .lf_src_sel(lf_src_sel), .lf_bypass(lf_bypass),
  .lf_external(lf_external), .lf_start_pulse(lf_start_pulse)
);
